// ---- logic/mxc_ports.v ----
// Management port and transceiver configuration port of the core.
// Assumes the host keeps strobes steady during stall and never reads and writes at once.
`default_nettype none
`include "mxc_defs.vh"

module mxc_ports (
  input  wire                         clock,               // Management clock, 125 MHz
  input  wire                         nrst,                // Async reset, active low
  input  wire                         mgmt_rd_strobe,      // Management read request
  input  wire                         mgmt_wr_strobe,      // Management write request
  input  wire [`MXC_MGMT_ADDR_W-1:0]  mgmt_reg_address,    // Management address
  input  wire [`MXC_DATA_W-1:0]       mgmt_write_bus,      // Management write data
  output reg  [`MXC_DATA_W-1:0]       mgmt_read_bus,       // Management read data
  output reg                          mgmt_read_bus_valid, // Read data valid pulse
  input  wire                         xcvr_cfg_reset,      // Sync reset, active high
  input  wire                         xcvr_cfg_rd_strobe,  // Configuration read request
  input  wire                         xcvr_cfg_wr_strobe,  // Configuration write request
  input  wire [`MXC_CFG_ADDR_W-1:0]   xcvr_cfg_address,    // Channel select and offset
  input  wire [`MXC_DATA_W-1:0]       xcvr_cfg_write_bus,  // Configuration write data
  output reg  [`MXC_DATA_W-1:0]       xcvr_cfg_read_bus,   // Configuration read data
  output wire                         xcvr_cfg_stall       // Busy, read data not ready
);

  // ****************************************************************
  // Management port
  // ****************************************************************
  wire                          mgmt_in_scratch;
  wire                          mgmt_wr_go;
  wire                          mgmt_rd_go;
  wire [`MXC_DATA_W-1:0]        mgmt_bank_q;
  reg  [`MXC_DATA_W-1:0]        rate_count;
  reg  [`MXC_DATA_W-1:0]        rate_snap;
  reg  [1:0]                    rd_sel;
  reg                           rd_pend;
  reg  [7:0]                    wr_count;
  reg  [7:0]                    rd_count;

  assign mgmt_in_scratch = (mgmt_reg_address <= `MXC_MGMT_SCRATCH_HI);
  // Reads win nothing over writes; both at once is ignored
  assign mgmt_wr_go = mgmt_wr_strobe & ~mgmt_rd_strobe;
  assign mgmt_rd_go = mgmt_rd_strobe & ~mgmt_wr_strobe;

  mxc_regbank #(
    .AW (`MXC_MGMT_BANK_AW),
    .DW (`MXC_DATA_W)
  ) u_mgmt_bank (
    .clock (clock),
    .nrst  (nrst),
    .we    (mgmt_wr_go & mgmt_in_scratch),
    .waddr (mgmt_reg_address[`MXC_MGMT_BANK_AW-1:0]),
    .wdata (mgmt_write_bus),
    .re    (mgmt_rd_go & mgmt_in_scratch),
    .raddr (mgmt_reg_address[`MXC_MGMT_BANK_AW-1:0]),
    .rdata (mgmt_bank_q)
  );

  // Clock rate monitor: free-running count of management clock edges
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rate_count <= 32'h00000000;
    end else begin
      rate_count <= rate_count + 32'h00000001;
    end
  end

  // Stage one: take the request, note the source
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_pend   <= 1'b0;
      rd_sel    <= 2'h0;
      rate_snap <= 32'h00000000;
      wr_count  <= 8'h00;
      rd_count  <= 8'h00;
    end else begin
      rd_pend <= mgmt_rd_go;
      if (mgmt_rd_go) begin
        rate_snap <= rate_count;
        rd_count  <= rd_count + 8'h01;
        if (mgmt_in_scratch) begin
          rd_sel <= 2'h0;
        end else if (mgmt_reg_address == `MXC_MGMT_RATE_ADDR) begin
          rd_sel <= 2'h1;
        end else if (mgmt_reg_address == `MXC_MGMT_STAT_ADDR) begin
          rd_sel <= 2'h2;
        end else begin
          rd_sel <= 2'h3;
        end
      end
      if (mgmt_wr_go) begin
        wr_count <= wr_count + 8'h01;
      end
    end
  end

  // Stage two: data and valid leave together
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mgmt_read_bus       <= 32'h00000000;
      mgmt_read_bus_valid <= 1'b0;
    end else begin
      mgmt_read_bus_valid <= rd_pend;
      if (rd_pend) begin
        case (rd_sel)
          2'h0: begin
            mgmt_read_bus <= mgmt_bank_q;
          end
          2'h1: begin
            mgmt_read_bus <= rate_snap;
          end
          2'h2: begin
            mgmt_read_bus <= {16'h0000, wr_count, rd_count};
          end
          default: begin
            mgmt_read_bus <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Transceiver configuration port
  // ****************************************************************
  // Configuration read states
  localparam [1:0] CFG_IDLE = `MXC_ST_IDLE;
  localparam [1:0] CFG_BUSY = `MXC_ST_BUSY;
  localparam [1:0] CFG_DONE = `MXC_ST_DONE;

  wire [`MXC_CFG_BASE_AW-1:0]   cfg_channel;
  wire [`MXC_CFG_OFS_W-1:0]     cfg_offset;
  wire                          cfg_in_bank;
  wire [`MXC_CFG_BANK_AW-1:0]   cfg_index;
  wire                          cfg_wr_go;
  wire                          cfg_rd_go;
  wire [`MXC_DATA_W-1:0]        cfg_bank_q;
  reg  [1:0]                    cfg_state;
  reg  [1:0]                    next_cfg_state;
  reg  [2:0]                    cfg_wait;
  reg                           cfg_hit;

  // Channel select above the register offset
  assign cfg_channel = xcvr_cfg_address[`MXC_CFG_ADDR_W-1:`MXC_CFG_OFS_W];
  assign cfg_offset  = xcvr_cfg_address[`MXC_CFG_OFS_W-1:0];
  // Offsets past the stored slots: writes dropped, reads give zero
  assign cfg_in_bank = (cfg_offset[`MXC_CFG_OFS_W-1:`MXC_CFG_SLOT_W] == 8'h00);
  assign cfg_index   = {cfg_channel, cfg_offset[`MXC_CFG_SLOT_W-1:0]};
  assign cfg_wr_go   = xcvr_cfg_wr_strobe & ~xcvr_cfg_rd_strobe & ~xcvr_cfg_reset;
  // Taken only from idle, so a held strobe is not taken twice
  assign cfg_rd_go   = xcvr_cfg_rd_strobe & ~xcvr_cfg_wr_strobe & ~xcvr_cfg_reset
                       & (cfg_state == CFG_IDLE);

  mxc_regbank #(
    .AW (`MXC_CFG_BANK_AW),
    .DW (`MXC_DATA_W)
  ) u_cfg_bank (
    .clock (clock),
    .nrst  (nrst),
    .we    (cfg_wr_go & cfg_in_bank),
    .waddr (cfg_index),
    .wdata (xcvr_cfg_write_bus),
    .re    (cfg_rd_go),
    .raddr (cfg_index),
    .rdata (cfg_bank_q)
  );

  always @* begin
    next_cfg_state = cfg_state;
    case (cfg_state)
      CFG_IDLE: begin
        if (cfg_rd_go) begin
          next_cfg_state = CFG_BUSY;
        end
      end
      CFG_BUSY: begin
        if (cfg_wait == 3'h1) begin
          next_cfg_state = CFG_DONE;
        end
      end
      CFG_DONE: begin
        next_cfg_state = CFG_IDLE;
      end
      default: begin
        next_cfg_state = CFG_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_state         <= CFG_IDLE;
      cfg_wait          <= 3'h0;
      cfg_hit           <= 1'b0;
      xcvr_cfg_read_bus <= 32'h00000000;
    end else if (xcvr_cfg_reset) begin
      cfg_state         <= CFG_IDLE;
      cfg_wait          <= 3'h0;
      cfg_hit           <= 1'b0;
      xcvr_cfg_read_bus <= 32'h00000000;
    end else begin
      cfg_state <= next_cfg_state;
      if (cfg_rd_go) begin
        cfg_wait <= `MXC_CFG_RD_LAT;
        cfg_hit  <= cfg_in_bank;
      end else if (cfg_wait != 3'h0) begin
        cfg_wait <= cfg_wait - 3'h1;
      end
      // Data is loaded on the same edge that drops stall
      if ((cfg_state == CFG_BUSY) && (next_cfg_state == CFG_DONE)) begin
        xcvr_cfg_read_bus <= cfg_hit ? cfg_bank_q : 32'h00000000;
      end
    end
  end

  // Stall while a read waits for data, and during reset
  // Low for the one done cycle; host drops the read strobe in the cycle after it
  assign xcvr_cfg_stall = xcvr_cfg_reset |
                          (xcvr_cfg_rd_strobe & (cfg_state != CFG_DONE));

endmodule

`default_nettype wire

// ---- inc/mxc_defs.vh ----
// Constants for the management and transceiver configuration ports.
// Assumes a single 125 MHz clock shared by both ports.
//
// Contract
// - Every management access and the clock rate monitor run on the management clock.
// - The core drives valid 32-bit read data whenever it raises the read-valid flag.
// - The configuration address holds a channel select above an 11-bit register offset.
// - The core presents valid 32-bit read data when it drops its stall after a read.
// - The core holds the configuration stall high while read data is not yet ready.
`ifndef MXC_DEFS_VH
`define MXC_DEFS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define MXC_DATA_W          32
`define MXC_MGMT_ADDR_W     16
`define MXC_MGMT_BANK_AW    4
`define MXC_CFG_BASE_AW     4
`define MXC_CFG_OFS_W       11
`define MXC_CFG_ADDR_W      (`MXC_CFG_BASE_AW + `MXC_CFG_OFS_W)
`define MXC_CFG_SLOT_W      3
`define MXC_CFG_BANK_AW     (`MXC_CFG_BASE_AW + `MXC_CFG_SLOT_W)

// ****************************************************************
// Management map
// ****************************************************************
`define MXC_MGMT_SCRATCH_HI 16'h000F
`define MXC_MGMT_RATE_ADDR  16'h0010
`define MXC_MGMT_STAT_ADDR  16'h0011

// ****************************************************************
// Configuration timing and states
// ****************************************************************
`define MXC_CFG_RD_LAT      3'h3
`define MXC_ST_IDLE         2'h0
`define MXC_ST_BUSY         2'h1
`define MXC_ST_DONE         2'h2

`endif

// ---- logic/mxc_regbank.v ----
// Word store with one write port and one registered read port.
// Assumes both ports are on the same clock; contents are not reset.
`default_nettype none

module mxc_regbank #(
  parameter AW = 4,
  parameter DW = 32
) (
  input  wire          clock,  // Port clock
  input  wire          nrst,   // Async reset, active low
  input  wire          we,     // Write enable
  input  wire [AW-1:0] waddr,  // Write index
  input  wire [DW-1:0] wdata,  // Write data
  input  wire          re,     // Read enable
  input  wire [AW-1:0] raddr,  // Read index
  output reg  [DW-1:0] rdata   // Read data, one cycle after re
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= {DW{1'b0}};
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

`default_nettype wire

// ---- tb/mxc_ports_properties.sv ----
// Checker for the management and configuration ports of the core.
// Assumes it is bound to mxc_ports and sees only its ports.
`default_nettype none
`include "mxc_defs.vh"
module mxc_ports_properties (
  input wire logic                       clock,
  input wire logic                       nrst,
  input wire logic                       mgmt_rd_strobe,
  input wire logic                       mgmt_wr_strobe,
  input wire logic [`MXC_MGMT_ADDR_W-1:0] mgmt_reg_address,
  input wire logic [`MXC_DATA_W-1:0]     mgmt_write_bus,
  input wire logic [`MXC_DATA_W-1:0]     mgmt_read_bus,
  input wire logic                       mgmt_read_bus_valid,
  input wire logic                       xcvr_cfg_reset,
  input wire logic                       xcvr_cfg_rd_strobe,
  input wire logic                       xcvr_cfg_wr_strobe,
  input wire logic [`MXC_CFG_ADDR_W-1:0] xcvr_cfg_address,
  input wire logic [`MXC_DATA_W-1:0]     xcvr_cfg_write_bus,
  input wire logic [`MXC_DATA_W-1:0]     xcvr_cfg_read_bus,
  input wire logic                       xcvr_cfg_stall
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_mgmt_take;
    mgmt_rd_strobe && !mgmt_wr_strobe;
  endsequence
  sequence s_cfg_take;
    $rose(xcvr_cfg_rd_strobe) && !xcvr_cfg_wr_strobe && !xcvr_cfg_reset;
  endsequence
  sequence s_cfg_wait;
    xcvr_cfg_stall [*4] ##1 !xcvr_cfg_stall;
  endsequence
  AST_MGMT_RD_LAT: assert property (s_mgmt_take |-> ##2 mgmt_read_bus_valid)
    else $error("management read not answered two cycles later");
  AST_MGMT_VALID_CAUSE: assert property (mgmt_read_bus_valid |-> $past(mgmt_rd_strobe, 2))
    else $error("read valid without a read request");
  AST_MGMT_BUS_HOLD: assert property (!mgmt_read_bus_valid |-> $stable(mgmt_read_bus))
    else $error("management read bus moved without valid");
  AST_MGMT_BOTH_IGNORED: assert property (mgmt_rd_strobe && mgmt_wr_strobe |-> ##2 !mgmt_read_bus_valid)
    else $error("read with write strobe was answered");
  AST_CFG_RD_WAIT: assert property (disable iff (!nrst || xcvr_cfg_reset)
    s_cfg_take |-> s_cfg_wait)
    else $error("configuration stall length wrong");
  AST_CFG_IDLE_FREE: assert property (!xcvr_cfg_rd_strobe && !xcvr_cfg_reset |-> !xcvr_cfg_stall)
    else $error("stall high with no read pending");
  AST_CFG_RST_STALL: assert property (xcvr_cfg_reset |-> xcvr_cfg_stall)
    else $error("stall low during configuration reset");
  AST_CFG_RST_DATA: assert property (xcvr_cfg_reset |=> xcvr_cfg_read_bus == 32'h0)
    else $error("configuration read bus not cleared by reset");
endmodule
bind mxc_ports mxc_ports_properties chk (.clock(clock), .nrst(nrst),
  .mgmt_rd_strobe(mgmt_rd_strobe), .mgmt_wr_strobe(mgmt_wr_strobe),
  .mgmt_reg_address(mgmt_reg_address), .mgmt_write_bus(mgmt_write_bus),
  .mgmt_read_bus(mgmt_read_bus), .mgmt_read_bus_valid(mgmt_read_bus_valid),
  .xcvr_cfg_reset(xcvr_cfg_reset), .xcvr_cfg_rd_strobe(xcvr_cfg_rd_strobe),
  .xcvr_cfg_wr_strobe(xcvr_cfg_wr_strobe), .xcvr_cfg_address(xcvr_cfg_address),
  .xcvr_cfg_write_bus(xcvr_cfg_write_bus), .xcvr_cfg_read_bus(xcvr_cfg_read_bus),
  .xcvr_cfg_stall(xcvr_cfg_stall));
`default_nettype wire

// ---- tb/mxc_host.sv ----
// Host model issuing management and configuration accesses.
// Assumes a shared 125 MHz clock; drives on the falling edge.
`default_nettype none
module mxc_host (
  input  wire logic        clock,         // Port clock
  input  wire logic [31:0] m_rdata,       // Management read data
  input  wire logic        m_valid,       // Management read valid
  input  wire logic [31:0] c_rdata,       // Configuration read data
  input  wire logic        c_stall,       // Configuration stall
  output logic             m_rd,          // Management read strobe
  output logic             m_wr,          // Management write strobe
  output logic [15:0]      m_addr,        // Management address
  output logic [31:0]      m_wdata,       // Management write data
  output logic             c_rd,          // Configuration read strobe
  output logic             c_wr,          // Configuration write strobe
  output logic [14:0]      c_addr,        // Configuration address
  output logic [31:0]      c_wdata        // Configuration write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {m_rd, m_wr, c_rd, c_wr} = 4'h0;
    {m_addr, m_wdata, c_addr, c_wdata} = '0;
  end
  // Strobe one cycle, then scramble released data
  task automatic mgmt_wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clock);
    {m_wr, m_addr, m_wdata} = {1'b1, a, d};
    @(negedge clock);
    m_wr = 1'b0;
    m_wdata = ~d;
  endtask
  // Valid looked at one and two cycles after the take
  task automatic mgmt_rd(input logic [15:0] a, output logic [31:0] d, output logic v1,
                         output logic v2);
    @(negedge clock);
    {m_rd, m_addr} = {1'b1, a};
    @(negedge clock);
    m_rd = 1'b0;
    v1 = m_valid;
    @(negedge clock);
    v2 = m_valid;
    d = m_rdata;
  endtask
  // Both strobes at once; valid looked at where an answer would stand
  task automatic mgmt_both(input logic [15:0] a, input logic [31:0] d, output logic v);
    @(negedge clock);
    {m_rd, m_wr, m_addr, m_wdata} = {2'b11, a, d};
    @(negedge clock);
    {m_rd, m_wr} = 2'b00;
    m_wdata = ~d;
    @(negedge clock);
    v = m_valid;
  endtask
  task automatic cfg_wr(input logic [14:0] a, input logic [31:0] d);
    @(negedge clock);
    {c_wr, c_addr, c_wdata} = {1'b1, a, d};
    @(negedge clock);
    c_wr = 1'b0;
    c_wdata = ~d;
  endtask
  // Holds the request until stall is seen low just after a falling edge, then reads at the rising edge
  task automatic cfg_rd(input logic [14:0] a, output logic [31:0] d, output int n);
    n = 0;
    @(negedge clock);
    {c_rd, c_addr} = {1'b1, a};
    #1;
    while (c_stall !== 1'b0 && n < 20) begin
      @(negedge clock) #1 n++;
    end
    @(posedge clock) d = c_rdata;
    @(negedge clock) c_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_mgmt_and_xcvr_cfg_ports.sv ----
// Testbench for the management and configuration ports.
// Assumes mxc_ports, the host model and the checker are compiled first.
`default_nettype none
`include "mxc_defs.vh"
module tb_mgmt_and_xcvr_cfg_ports;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, nrst, cfg_rst, m_rd, m_wr, m_valid, c_rd, c_wr, c_stall, v1, v2;
  logic [15:0] m_addr;
  logic [14:0] c_addr;
  logic [31:0] m_wdata, m_rdata, c_wdata, c_rdata, d;
  int n_errors = 0, checks_done = 0, cycles = 0, n;
  mxc_host host (.clock(clock), .m_rdata(m_rdata), .m_valid(m_valid), .c_rdata(c_rdata),
    .c_stall(c_stall), .m_rd(m_rd), .m_wr(m_wr), .m_addr(m_addr), .m_wdata(m_wdata),
    .c_rd(c_rd), .c_wr(c_wr), .c_addr(c_addr), .c_wdata(c_wdata));
  mxc_ports uut (.clock(clock), .nrst(nrst), .mgmt_rd_strobe(m_rd), .mgmt_wr_strobe(m_wr),
    .mgmt_reg_address(m_addr), .mgmt_write_bus(m_wdata), .mgmt_read_bus(m_rdata),
    .mgmt_read_bus_valid(m_valid), .xcvr_cfg_reset(cfg_rst), .xcvr_cfg_rd_strobe(c_rd),
    .xcvr_cfg_wr_strobe(c_wr), .xcvr_cfg_address(c_addr), .xcvr_cfg_write_bus(c_wdata),
    .xcvr_cfg_read_bus(c_rdata), .xcvr_cfg_stall(c_stall));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Scratch words, an ignored out-of-range write, read latency
  task automatic test_mgmt();
    logic [15:0] a [3] = '{16'h0000, 16'h000F, 16'h0020};
    logic [31:0] e [3] = '{32'hA5A5_0001, 32'h5A5A_000F, 32'h0};
    for (int i = 0; i < 3; i++) host.mgmt_wr(a[i], ~e[i] ^ {16'h0, a[i]});
    for (int i = 0; i < 3; i++) host.mgmt_wr(a[i], e[i] | 32'hFFFF_0000 * (a[i] > 15));
    for (int i = 0; i < 3; i++) begin
      host.mgmt_rd(a[i], d, v1, v2);
      check(v1, 1'b0);
      check(v2, 1'b1);
      check(d, e[i]);
    end
    $display("test_mgmt done");
  endtask
  // Rate monitor spacing, status counters, both strobes refused
  task automatic test_mgmt_status();
    logic [31:0] s, r;
    host.mgmt_rd(16'h0011, s, v1, v2);
    host.mgmt_wr(16'h0002, 32'h0000_0002);
    host.mgmt_rd(16'h0010, r, v1, v2);
    host.mgmt_rd(16'h0010, d, v1, v2);
    check(d - r, 32'h0000_0003);
    host.mgmt_rd(16'h0011, d, v1, v2);
    check(d - s, 32'h0000_0103);
    host.mgmt_both(16'h0002, 32'hBAD0_0002, v1);
    check(v1, 1'b0);
    host.mgmt_rd(16'h0002, d, v1, v2);
    check(d, 32'h0000_0002);
    $display("test_mgmt_status done");
  endtask
  // Channel select, high offset, stall length
  task automatic test_cfg();
    host.cfg_wr({4'h2, 11'h003}, 32'h1234_5678);
    host.cfg_wr({4'h5, 11'h003}, 32'h8765_4321);
    host.cfg_wr({4'h2, 11'h009}, 32'hDEAD_BEEF);
    host.cfg_rd({4'h2, 11'h003}, d, n);
    check(d, 32'h1234_5678);
    check(n, `MXC_CFG_RD_LAT + 1);
    host.cfg_rd({4'h5, 11'h003}, d, n);
    check(d, 32'h8765_4321);
    host.cfg_rd({4'h2, 11'h009}, d, n);
    check(d, 32'h0);
    $display("test_cfg done");
  endtask
  task automatic test_cfg_reset();
    host.cfg_rd({4'h2, 11'h003}, d, n);
    check(d, 32'h1234_5678);
    @(negedge clock) cfg_rst = 1'b1;
    #1 check(c_stall, 1'b1);
    @(negedge clock) check(c_rdata, 32'h0);
    cfg_rst = 1'b0;
    host.mgmt_rd(16'h0000, d, v1, v2);
    check(d, 32'hA5A5_0001);
    host.cfg_rd({4'h5, 11'h003}, d, n);
    check(d, 32'h8765_4321);
    $display("test_cfg_reset done");
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    nrst = 1'b0;
    cfg_rst = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock) nrst = 1'b1;
    fork
      begin
        test_mgmt();
        test_mgmt_status();
        test_cfg();
        test_cfg_reset();
      end
      begin
        while (cycles < 3000) begin
          @(posedge clock);
          cycles++;
        end
        n_errors++;
        $display("[FAIL] %0t cycle limit reached", $time);
      end
    join_any
    give_verdict();
  end
endmodule
`default_nettype wire
